/* File: common/dac_i2c_pkg.sv */
// Purpose: Shared constants for the DAC two-wire slave interface.
// Assumes: Core clock of 250 MHz; single-channel volatile map.
// Notes: Memory locations hold 16-bit words; unused bits read as zero.
package dac_i2c_pkg;
    // Volatile storage geometry
    localparam int DAC_BITS = 12;
    localparam int PTR_BITS = 5;
    // Memory locations
    localparam logic [4:0] ADDR_DAC0 = 5'h00;
    localparam logic [4:0] ADDR_VREF = 5'h08;
    localparam logic [4:0] ADDR_PDOWN = 5'h09;
    localparam logic [4:0] ADDR_GAIN_STAT = 5'h0a;
    localparam logic [4:0] PTR_RESET = 5'h00;
    // Bit positions in the gain and status word
    localparam int GAIN_POS = 8;
    localparam int POR_POS = 7;
    localparam int ERR_POS = 6;
    // Factory defaults loaded at power-up and on general call reset
    localparam logic [DAC_BITS-1:0] DAC_DEFAULT = 12'h000;
    localparam logic [1:0] VREF_DEFAULT = 2'h0;
    localparam logic [1:0] PDOWN_DEFAULT = 2'h0;
    localparam logic GAIN_DEFAULT = 1'b0;
    // Command field of the command byte
    localparam logic [1:0] CMD_WRITE = 2'h0;
    localparam logic [1:0] CMD_READ = 2'h3;
    // Slave address: fixed upper five bits, two selectable low bits
    localparam logic [4:0] SLAVE_ADDR_BASE = 5'h18;
    localparam logic [7:0] GC_ADDR_BYTE = 8'h00;
    localparam logic [7:0] GC_CMD_RESET = 8'h06;
    localparam logic [7:0] GC_CMD_WAKE = 8'h0a;
    localparam logic [4:0] FAST_CODE_TOP = 5'h01;
    // Spike filter timing
    localparam int CLK_PERIOD_PS = 4000;
    localparam int SPIKE_NS = 10;
    localparam int SPIKE_CYC = (SPIKE_NS * 1000 + CLK_PERIOD_PS - 1)
                               / CLK_PERIOD_PS;
    localparam logic [3:0] BIT_COUNT_BYTE = 4'h8;
endpackage : dac_i2c_pkg

/* File: rtl/dac_i2c_slave_interface.sv */
// Purpose: Two-wire slave front end of a voltage-output DAC with its
//          volatile memory, address pointer and speed-mode control.
// Assumes: scl is also the clock of a small capture stage; all protocol
//          decisions are made in the clk domain from synchronised lines.
// Notes: The device never drives scl and never stretches the clock.

// Notes on behaviour
// - Five config bits, two status, 12-bit DAC
// - Defaults loaded at power-up before access
// - Power-on sets flag; status read clears
// - Slave only, never drives clock line
// - No clock stretching; read data ready
// - Works at 100k, 400k, 3.4M bit rates
// - Power-on/brown-out: idle, pointer zero
// - Memory address pointer is five bits
// - Pointer kept across Stop and Restart
// - General call: reset and wake-up decoded
// - Wake-up command leaves power-down
// - First byte: seven-bit address plus R/W
// - No ten-bit addressing supported
// - Address selectable 1100000 through 1100011
// - Fast code unacknowledged but enters fast mode
// - Only Stop or reset ends high-speed mode
// - Control byte follows; Restart keeps speed
// - Speed indication selects sda slope setting
// - High-speed scl filter drops sub-10ns spikes
// - General call reset loads defaults, not POR flag
// - Wake, reset, or write 00 clears power-down
// - Stop/Restart mid-data aborts and resets
module dac_i2c_slave_interface
    import dac_i2c_pkg::*;
#(
    parameter logic [1:0] ADDR_SEL = 2'h0
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic scl,
    input wire logic sda_i,
    input wire logic brown_out_event,
    output logic sda_o,
    output logic sda_oe_n,
    output logic hs_mode,
    output logic [DAC_BITS-1:0] dac_value,
    output logic [1:0] vref_select,
    output logic [1:0] power_down_select,
    output logic gain_select,
    output logic por_status
);

    typedef enum logic [2:0] {
        ST_IDLE, ST_ADDR, ST_CMD, ST_DATA_HI, ST_DATA_LO, ST_READ, ST_GC,
        ST_IGNORE
    } state_t;

    localparam logic [6:0] SLAVE_ADDR = {SLAVE_ADDR_BASE, ADDR_SEL};

    // Link side: sample sda on each scl rise and flag it with a toggle
    logic link_bit_reg;
    logic link_tog_reg;

    // Reset is taken at once: scl has no edge while the bus idles high
    always_ff @(posedge scl or posedge rst) begin
        if (rst) begin
            link_bit_reg <= 1'b0;
            link_tog_reg <= 1'b0;
        end else begin
            link_bit_reg <= sda_i;
            link_tog_reg <= ~link_tog_reg;
        end
    end

    // Two-flop synchronisers for every line entering the clk domain
    logic scl_s1, scl_s2, sda_s1, sda_s2, sda_prev_reg;
    logic tog_s1, tog_s2, tog_prev_reg, bit_s1, bit_s2;
    logic bo_s1, bo_s2;

    always_ff @(posedge clk) begin
        scl_s1 <= scl;
        scl_s2 <= scl_s1;
        sda_s1 <= sda_i;
        sda_s2 <= sda_s1;
        sda_prev_reg <= sda_s2;
        tog_s1 <= link_tog_reg;
        tog_s2 <= tog_s1;
        bit_s1 <= link_bit_reg;
        bit_s2 <= bit_s1;
        bo_s1 <= brown_out_event;
        bo_s2 <= bo_s1;
    end

    // Spike filter: in high-speed mode scl must hold its new level for
    // SPIKE_CYC cycles before the filtered copy follows it
    logic scl_f_reg;
    logic scl_f_prev_reg;
    logic [3:0] spike_cnt_reg;

    always_ff @(posedge clk) begin
        scl_f_prev_reg <= scl_f_reg;
        if (rst) begin
            scl_f_reg <= 1'b1;
            spike_cnt_reg <= 4'h0;
        end else if (scl_s2 == scl_f_reg) begin
            spike_cnt_reg <= 4'h0;
        end else if (!hs_mode ||
                     spike_cnt_reg == 4'(SPIKE_CYC - 1)) begin
            scl_f_reg <= scl_s2;
            spike_cnt_reg <= 4'h0;
        end else begin
            spike_cnt_reg <= spike_cnt_reg + 4'h1;
        end
    end

    // Bus events. A captured bit is taken only while the filtered clock
    // is high, so a gobbled spike cannot shift in a false bit.
    logic start_evt, stop_evt, rise_evt, fall_evt, any_reset;

    assign start_evt = scl_f_reg && sda_prev_reg && !sda_s2;
    assign stop_evt = scl_f_reg && !sda_prev_reg && sda_s2;
    assign rise_evt = (tog_s2 != tog_prev_reg) && scl_s2 && scl_f_reg;
    assign fall_evt = scl_f_prev_reg && !scl_f_reg;

    always_ff @(posedge clk) begin
        if (rst) begin
            tog_prev_reg <= tog_s2;
        end else if (tog_s2 != tog_prev_reg && (scl_s2 == scl_f_reg)) begin
            tog_prev_reg <= tog_s2;
        end
    end

    // Protocol state
    state_t state_reg;
    logic [7:0] shift_reg;
    logic [7:0] hi_byte_reg;
    logic [7:0] tx_reg;
    logic [3:0] bit_cnt_reg;
    logic ack_phase_reg;
    logic master_ack_reg;
    logic rd_lo_reg;
    logic [PTR_BITS-1:0] ptr_reg;
    logic gc_reset_reg;
    logic gc_wake_reg;
    logic wr_en_reg;
    logic [15:0] wr_word_reg;
    logic status_rd_reg;
    logic err_set_reg;
    logic hs_set_reg;
    logic err_flag_reg;

    assign any_reset = rst || bo_s2 || gc_reset_reg;

    // Memory read view of one location
    function automatic logic [15:0] word_at(input logic [PTR_BITS-1:0] a);
        logic [15:0] w;
        w = 16'h0000;
        if (a == ADDR_DAC0) begin
            w[DAC_BITS-1:0] = dac_value;
        end else if (a == ADDR_VREF) begin
            w[1:0] = vref_select;
        end else if (a == ADDR_PDOWN) begin
            w[1:0] = power_down_select;
        end else if (a == ADDR_GAIN_STAT) begin
            w[GAIN_POS] = gain_select;
            w[POR_POS] = por_status;
            w[ERR_POS] = err_flag_reg;
        end
        return w;
    endfunction : word_at

    function automatic logic valid_addr(input logic [PTR_BITS-1:0] a);
        return a == ADDR_DAC0 || a == ADDR_VREF || a == ADDR_PDOWN ||
               a == ADDR_GAIN_STAT;
    endfunction : valid_addr
    // Word at the pointer, shared by both halves of a read
    logic [15:0] cur_word;
    assign cur_word = word_at(ptr_reg);

    // Byte engine and command decode. sda only ever goes low under our
    // own drive; scl has no output at all, so it is never held.
    // Acks and read bits are ready at the scl fall, so no wait is
    // inserted at any bit rate.
    always_ff @(posedge clk) begin
        gc_reset_reg <= 1'b0;
        gc_wake_reg <= 1'b0;
        wr_en_reg <= 1'b0;
        status_rd_reg <= 1'b0;
        err_set_reg <= 1'b0;
        hs_set_reg <= 1'b0;
        if (any_reset) begin
            state_reg <= ST_IDLE;
            ptr_reg <= PTR_RESET;
            bit_cnt_reg <= 4'h0;
            ack_phase_reg <= 1'b0;
            master_ack_reg <= 1'b0;
            rd_lo_reg <= 1'b0;
            shift_reg <= 8'h00;
            hi_byte_reg <= 8'h00;
            tx_reg <= 8'h00;
            wr_word_reg <= 16'h0000;
            sda_oe_n <= 1'b1;
        end else if (start_evt || stop_evt) begin
            // Abort: a half-received word is simply never written
            state_reg <= start_evt ? ST_ADDR : ST_IDLE;
            bit_cnt_reg <= 4'h0;
            ack_phase_reg <= 1'b0;
            sda_oe_n <= 1'b1; // Pointer kept untouched
        end else if (rise_evt && state_reg != ST_IDLE) begin
            if (ack_phase_reg) begin
                master_ack_reg <= !bit_s2;
            end else if (bit_cnt_reg != BIT_COUNT_BYTE) begin
                shift_reg <= {shift_reg[6:0], bit_s2};
                bit_cnt_reg <= bit_cnt_reg + 4'h1;
            end
        end else if (fall_evt && state_reg != ST_IDLE) begin
            if (ack_phase_reg) begin
                // End of the ack slot
                ack_phase_reg <= 1'b0;
                bit_cnt_reg <= 4'h0;
                sda_oe_n <= 1'b1;
                if (state_reg == ST_READ) begin
                    if (master_ack_reg) begin
                        sda_oe_n <= tx_reg[7];
                    end else begin
                        state_reg <= ST_IGNORE;
                    end
                end else if (state_reg == ST_GC &&
                             shift_reg == GC_CMD_RESET) begin
                    gc_reset_reg <= 1'b1; // Fires once acked
                end
            end else if (bit_cnt_reg == BIT_COUNT_BYTE) begin
                ack_phase_reg <= 1'b1;
                sda_oe_n <= 1'b1;
                case (state_reg)
                    ST_ADDR: begin
                        if (shift_reg[7:1] == SLAVE_ADDR) begin
                            sda_oe_n <= 1'b0;
                            if (shift_reg[0]) begin
                                state_reg <= ST_READ;
                                tx_reg <= cur_word[15:8];
                                rd_lo_reg <= 1'b1;
                            end else begin
                                state_reg <= ST_CMD;
                            end
                        end else if (shift_reg == GC_ADDR_BYTE) begin
                            sda_oe_n <= 1'b0;
                            state_reg <= ST_GC;
                        end else if (shift_reg[7:3] == FAST_CODE_TOP) begin
                            // Left unacknowledged, yet switches
                            hs_set_reg <= 1'b1;
                            state_reg <= ST_IGNORE;
                        end else begin
                            // Ten-bit headers never match
                            state_reg <= ST_IGNORE;
                        end
                    end
                    ST_CMD: begin
                        if (valid_addr(shift_reg[7:3]) &&
                            (shift_reg[2:1] == CMD_WRITE ||
                             shift_reg[2:1] == CMD_READ)) begin
                            ptr_reg <= shift_reg[7:3];
                            sda_oe_n <= 1'b0;
                            state_reg <= (shift_reg[2:1] == CMD_WRITE) ?
                                ST_DATA_HI : ST_IGNORE;
                        end else begin
                            err_set_reg <= 1'b1;
                            state_reg <= ST_IGNORE;
                        end
                    end
                    ST_DATA_HI: begin
                        hi_byte_reg <= shift_reg;
                        sda_oe_n <= 1'b0;
                        state_reg <= ST_DATA_LO;
                    end
                    ST_DATA_LO: begin
                        // Written during the ack, never before it
                        wr_word_reg <= {hi_byte_reg, shift_reg};
                        wr_en_reg <= 1'b1;
                        sda_oe_n <= 1'b0;
                        state_reg <= ST_CMD;
                    end
                    ST_GC: begin
                        if (shift_reg == GC_CMD_RESET) begin
                            // Ack now; the reset waits for the ack's end
                            sda_oe_n <= 1'b0;
                        end else if (shift_reg == GC_CMD_WAKE) begin
                            sda_oe_n <= 1'b0;
                            gc_wake_reg <= 1'b1;
                            state_reg <= ST_IGNORE;
                        end else begin
                            state_reg <= ST_IGNORE;
                        end
                    end
                    ST_READ: begin
                        // Release for the master's ack; queue next byte
                        tx_reg <= rd_lo_reg ? cur_word[7:0] : cur_word[15:8];
                        rd_lo_reg <= !rd_lo_reg;
                        // Flags clear only once the low byte holds them
                        status_rd_reg <= rd_lo_reg &&
                                         (ptr_reg == ADDR_GAIN_STAT);
                    end
                    default: begin
                        state_reg <= ST_IGNORE;
                    end
                endcase
            end else if (state_reg == ST_READ && bit_cnt_reg != 4'h0) begin
                sda_oe_n <= tx_reg[3'h7 - bit_cnt_reg[2:0]];
            end
        end
    end

    // Open-drain data: the level driven is always low
    always_ff @(posedge clk) begin
        sda_o <= 1'b0;
    end

    // Speed mode: set by the fast code, cleared only by Stop or reset
    always_ff @(posedge clk) begin
        if (any_reset || stop_evt) begin
            hs_mode <= 1'b0;
        end else if (hs_set_reg) begin
            hs_mode <= 1'b1; // Restart keeps it set
        end
    end

    // Volatile memory with factory defaults on any reset
    always_ff @(posedge clk) begin
        if (any_reset) begin
            dac_value <= DAC_DEFAULT;
            vref_select <= VREF_DEFAULT;
            power_down_select <= PDOWN_DEFAULT;
            gain_select <= GAIN_DEFAULT;
        end else if (gc_wake_reg) begin
            power_down_select <= 2'h0;
        end else if (wr_en_reg) begin
            if (ptr_reg == ADDR_DAC0) begin
                dac_value <= wr_word_reg[DAC_BITS-1:0];
            end else if (ptr_reg == ADDR_VREF) begin
                vref_select <= wr_word_reg[1:0];
            end else if (ptr_reg == ADDR_PDOWN) begin
                power_down_select <= wr_word_reg[1:0];
            end else if (ptr_reg == ADDR_GAIN_STAT) begin
                gain_select <= wr_word_reg[GAIN_POS];
            end
        end
    end

    // Status bits. The power-on flag is set only by power-up and cleared
    // by reading the status word; brown-out also counts as power-on.
    always_ff @(posedge clk) begin
        if (rst || bo_s2) begin
            por_status <= 1'b1;
        end else if (status_rd_reg) begin
            por_status <= 1'b0;
        end
        if (any_reset) begin
            err_flag_reg <= 1'b0;
        end else if (err_set_reg) begin
            err_flag_reg <= 1'b1;
        end else if (status_rd_reg) begin
            err_flag_reg <= 1'b0;
        end
    end

endmodule : dac_i2c_slave_interface

/* File: testbench/dac_i2c_slave_interface_assertions.sv */
// Purpose: Port-level assertions for the DAC two-wire slave interface.
// Assumes: The master holds each bus clock phase for many core cycles.
// Notes: Brown-out timing is loose, so rules near it are masked by it.
module dac_i2c_slave_interface_assertions
    import dac_i2c_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic scl,
    input wire logic sda_i,
    input wire logic brown_out_event,
    input wire logic sda_o,
    input wire logic sda_oe_n,
    input wire logic hs_mode,
    input wire logic [DAC_BITS-1:0] dac_value,
    input wire logic [1:0] vref_select,
    input wire logic [1:0] power_down_select,
    input wire logic gain_select,
    input wire logic por_status
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    // Defaults must already stand at the first edge after release
    a_reset_defaults: assert property (
        $fell(rst) |-> sda_oe_n && !hs_mode && por_status
        && dac_value == DAC_DEFAULT) else $error("reset defaults wrong");
    // Pin may only pull low, like an open-drain driver
    a_drive_only_low: assert property (
        !sda_o) else $error("sda driven high");
    // No stretching: the data answer moves only while the clock is low
    a_no_wait: assert property (disable iff (rst || brown_out_event)
        $changed(sda_oe_n) |-> !scl) else $error("sda moved with scl high");
    // Power-on flag is raised only by a reset event
    a_por_only_reset: assert property (
        disable iff (rst || brown_out_event)
        $rose(por_status) |-> $past(rst)) else $error("por set without reset");
    // Master code is left unanswered while speed mode comes on
    a_fast_code_nack: assert property (
        $rose(hs_mode) |-> sda_oe_n [*8]) else $error("master code acked");
    // Speed mode can only end on a data rise, i.e. a Stop
    a_hs_until_stop: assert property (
        disable iff (rst || brown_out_event)
        hs_mode && !sda_i && !$past(sda_i, 6) |=> hs_mode)
        else $error("speed mode left without stop");
    // Idle bus must leave the DAC value, power-down bits and power-on flag untouched
    a_idle_stable: assert property (
        disable iff (rst || brown_out_event)
        scl && sda_i && $past(scl, 8) && $past(sda_i, 8) |->
        $stable(dac_value) && $stable(power_down_select)
        && $stable(por_status)) else $error("state moved on idle bus");
    // A held brown-out returns the block to power-on values
    a_brown_out_reset: assert property (
        brown_out_event [*4] |=> por_status && !hs_mode
        && dac_value == DAC_DEFAULT && power_down_select == PDOWN_DEFAULT)
        else $error("brown-out did not reset");
    c_fast_mode: cover property ($rose(hs_mode));
    c_status_clear: cover property ($fell(por_status));
    c_ack_driven: cover property ($fell(sda_oe_n) ##[1:400] $rose(sda_oe_n));
endmodule : dac_i2c_slave_interface_assertions

bind dac_i2c_slave_interface dac_i2c_slave_interface_assertions chk (
    .clk(clk), .rst(rst), .scl(scl), .sda_i(sda_i),
    .brown_out_event(brown_out_event), .sda_o(sda_o), .sda_oe_n(sda_oe_n),
    .hs_mode(hs_mode), .dac_value(dac_value), .vref_select(vref_select),
    .power_down_select(power_down_select), .gain_select(gain_select),
    .por_status(por_status)
);

/* File: testbench/i2c_master_model.sv */
// Purpose: Behavioural bus master driving the clock and data lines.
// Assumes: Data line has a pull-up; released means read back as 1.
// Notes: Clock idles high between frames; only this master drives it.
module i2c_master_model (
    output logic scl,
    output logic sda_level,
    input wire logic sda
);
    timeunit 1ns;
    timeprecision 100ps;
    // HALF is odd, but each delay uses HALF / 2, so a bus clock phase is 160 ns, 40 core cycles
    localparam int HALF = 161;
    logic r;
    initial begin
        scl = 1'b1;
        sda_level = 1'b1;
    end
    // Data set mid-low, sampled mid-high
    task automatic bit_slot(input logic b, output logic q);
        #(HALF / 2) sda_level = b;
        #(HALF / 2) scl = 1'b1;
        #(HALF / 2) q = sda;
        #(HALF / 2) scl = 1'b0;
    endtask : bit_slot
    // Start or repeated start: data falls while clock is high
    task automatic start();
        #(HALF / 2) sda_level = 1'b1;
        #(HALF / 2) scl = 1'b1;
        #(HALF / 2) sda_level = 1'b0;
        #(HALF / 2) scl = 1'b0;
    endtask : start
    // Short clock pulse while low; only the speed-mode filter drops it
    task automatic glitch();
        #(HALF / 4) scl = 1'b1;
        #7 scl = 1'b0;
    endtask : glitch
    // Stop, then a long idle so the slave settles
    task automatic stop();
        #(HALF / 2) sda_level = 1'b0;
        #(HALF / 2) scl = 1'b1;
        #(HALF / 2) sda_level = 1'b1;
        #(HALF * 2);
    endtask : stop
    // Byte MSB first; ninth slot is released to read the answer
    task automatic send_byte(input logic [7:0] d, output logic ack);
        for (int i = 7; i >= 0; i--) begin
            bit_slot(d[i], r);
        end
        bit_slot(1'b1, ack);
    endtask : send_byte
    // Byte in MSB first; master gives ack (0) or nack (1)
    task automatic recv_byte(input logic ack, output logic [7:0] d);
        for (int i = 7; i >= 0; i--) begin
            bit_slot(1'b1, d[i]);
        end
        bit_slot(ack, r);
    endtask : recv_byte
endmodule : i2c_master_model

/* File: testbench/dac_i2c_slave_interface_bench.sv */
// Purpose: Self-checking bench for the DAC two-wire slave interface.
// Assumes: Behavioural master; pull-up on the data wire.
// Notes: Address select 2 so the low address bits are not all zero.
module dac_i2c_slave_interface_bench import dac_i2c_pkg::*;;
    timeunit 1ns;
    timeprecision 100ps;
    localparam logic [1:0] SEL = 2'h2;
    localparam logic [7:0] DEV_W = {SLAVE_ADDR_BASE, SEL, 1'b0};
    localparam logic [7:0] DEV_R = {SLAVE_ADDR_BASE, SEL, 1'b1};
    logic clk, rst, brown_out_event, sda_o, sda_oe_n, hs_mode;
    logic gain_select, por_status, scl, sda_level, sda, ack;
    logic [DAC_BITS-1:0] dac_value;
    logic [1:0] vref_select, power_down_select;
    logic [15:0] w;
    int fails, checks;
    // Wired-and of both parties; released wire floats high
    assign sda = sda_level & (sda_oe_n | sda_o);
    dac_i2c_slave_interface #(.ADDR_SEL(SEL)) DUT (
        .clk(clk), .rst(rst), .scl(scl), .sda_i(sda),
        .brown_out_event(brown_out_event), .sda_o(sda_o),
        .sda_oe_n(sda_oe_n), .hs_mode(hs_mode), .dac_value(dac_value),
        .vref_select(vref_select), .power_down_select(power_down_select),
        .gain_select(gain_select), .por_status(por_status));
    i2c_master_model bus (.scl(scl), .sda_level(sda_level), .sda(sda));
    // Core clock, 4 ns period
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    task automatic check_val(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp) begin
            fails++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check_val
    task automatic check_bit(input logic got, input logic exp);
        check_val({15'h0, got}, {15'h0, exp});
    endtask : check_bit
    task automatic check_outs(input logic [11:0] dac, input logic [1:0] pd);
        check_val({4'h0, dac_value}, {4'h0, dac});
        check_val({14'h0, power_down_select}, {14'h0, pd});
        check_bit(hs_mode, 1'b0);
    endtask : check_outs
    task automatic write_word(input logic [4:0] ptr, input logic [15:0] d);
        bus.start();
        bus.send_byte(DEV_W, ack);
        check_bit(ack, 1'b0);
        bus.send_byte({ptr, CMD_WRITE, 1'b0}, ack);
        bus.send_byte(d[15:8], ack);
        bus.send_byte(d[7:0], ack);
        check_bit(ack, 1'b0);
        bus.stop();
    endtask : write_word
    task automatic gen_call(input logic [7:0] code);
        bus.start();
        bus.send_byte(GC_ADDR_BYTE, ack);
        check_bit(ack, 1'b0);
        bus.send_byte(code, ack);
        check_bit(ack, 1'b0);
        bus.stop();
    endtask : gen_call
    // Optionally points at a location first, then reads one word
    task automatic read_word(input logic set, input logic [4:0] ptr);
        bus.start();
        if (set) begin
            bus.send_byte(DEV_W, ack);
            bus.send_byte({ptr, CMD_READ, 1'b0}, ack);
            bus.start();
        end
        bus.send_byte(DEV_R, ack);
        check_bit(ack, 1'b0);
        bus.recv_byte(1'b0, w[15:8]);
        bus.recv_byte(1'b1, w[7:0]);
        bus.stop();
    endtask : read_word
    task automatic report_and_stop();
        $display("comparisons %0d, mismatches %0d", checks, fails);
        if (fails == 0 && checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : report_and_stop
    // Watchdog: a hang counts as a mismatch
    initial begin
        repeat (60000) @(posedge clk);
        fails++;
        report_and_stop();
    end
    // Main sequence
    initial begin
        rst = 1'b1;
        brown_out_event = 1'b0;
        repeat (10) @(posedge clk);
        #1 rst = 1'b0;
        repeat (4) @(posedge clk);
        check_outs(12'h000, 2'h0);
        check_bit(por_status, 1'b1);
        write_word(ADDR_DAC0, 16'h0155);
        write_word(ADDR_PDOWN, 16'h0003);
        write_word(ADDR_VREF, 16'h0002);
        check_val({14'h0, vref_select}, 16'h0002);
        check_val({14'h0, power_down_select}, 16'h0003);
        gen_call(GC_CMD_WAKE);
        check_outs(12'h155, 2'h0);
        // Foreign address and a ten-bit header are both refused
        bus.start();
        bus.send_byte({SLAVE_ADDR_BASE, SEL ^ 2'h1, 1'b0}, ack);
        check_bit(ack, 1'b1);
        bus.start();
        bus.send_byte(8'hf0, ack);
        check_bit(ack, 1'b1);
        bus.stop();
        // Stop in place of the low data byte discards the word
        bus.start();
        bus.send_byte(DEV_W, ack);
        bus.send_byte({ADDR_DAC0, CMD_WRITE, 1'b0}, ack);
        bus.send_byte(8'h0f, ack);
        bus.stop();
        check_outs(12'h155, 2'h0);
        read_word(1'b1, ADDR_DAC0);
        check_val(w, 16'h0155);
        read_word(1'b1, ADDR_GAIN_STAT);
        check_val({14'h0, w[GAIN_POS], w[POR_POS]}, 16'h0001);
        check_bit(por_status, 1'b0);
        read_word(1'b0, ADDR_DAC0);
        check_val({14'h0, w[GAIN_POS], w[POR_POS]}, 16'h0000);
        // Master code, then a control byte in high-speed mode
        bus.start();
        bus.send_byte({FAST_CODE_TOP, 3'h3}, ack);
        check_bit(ack, 1'b1);
        check_bit(hs_mode, 1'b1);
        bus.start();
        bus.glitch();
        bus.send_byte(DEV_W, ack);
        check_bit(ack, 1'b0);
        check_bit(hs_mode, 1'b1);
        bus.stop();
        check_bit(hs_mode, 1'b0);
        @(posedge clk);
        #1 brown_out_event = 1'b1;
        repeat (10) @(posedge clk);
        #1 brown_out_event = 1'b0;
        repeat (6) @(posedge clk);
        check_outs(12'h000, 2'h0);
        check_bit(por_status, 1'b1);
        write_word(ADDR_DAC0, 16'h0abc);
        write_word(ADDR_PDOWN, 16'h0001);
        write_word(ADDR_GAIN_STAT, 16'h0100);
        check_bit(gain_select, 1'b1);
        gen_call(GC_CMD_RESET);
        check_outs(12'h000, 2'h0);
        check_bit(gain_select, 1'b0);
        report_and_stop();
    end
endmodule : dac_i2c_slave_interface_bench
